// ===== wiper_pkg.sv
// constants and types shared by the wiper control block
package wiper_pkg;

    // serial address layout
    localparam logic [3:0] ADDR_PREFIX       = 4'h5;
    localparam int         ADDR_BITS         = 7;
    localparam int         BYTE_BITS         = 8;
    localparam logic [3:0] BIT_COUNT_FULL    = 4'h8;

    // command byte codes
    localparam logic [7:0] CMD_WRITE_VOLATILE       = 8'h11;
    localparam logic [7:0] CMD_WRITE_NONVOLATILE    = 8'h21;
    localparam logic [7:0] CMD_RECALL_TO_VOLATILE   = 8'h61;
    localparam logic [7:0] CMD_STORE_TO_NONVOLATILE = 8'h51;

    // wiper field in the data byte
    localparam int         TAP_COUNT         = 32;
    localparam int         TAP_BITS          = 5;
    localparam int         TAP_FIELD_LSB     = 3;
    localparam logic [4:0] NV_FACTORY_VALUE  = 5'h00;
    localparam logic [4:0] VOL_RESET_VALUE   = 5'h00;

    // factory address options
    localparam logic       ADDR_BIT_TWO_DEFAULT  = 1'b0;
    localparam logic       ADDR_BIT_ONE_DEFAULT  = 1'b0;
    localparam logic       ADDR_BIT_ZERO_DEFAULT = 1'b0;

    // timing
    localparam int CLK_PERIOD_NS   = 50;
    localparam int STORE_TIME_MS   = 12;
    localparam int RECALL_TIME_US  = 20;
    localparam int STORE_CYCLES    =
        (STORE_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECALL_CYCLES_RAW = (RECALL_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int RECALL_CYCLES   = (RECALL_CYCLES_RAW < 1) ? 1 : RECALL_CYCLES_RAW;

    // one completed write transaction, passed from the link to the core
    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] data;
    } cmd_word_s;

endpackage

// ===== cmd_cross.sv
// toggle handshake carrying one command word from the link clock to the core clock
`timescale 1ns/100ps
`default_nettype none
module cmd_cross (
    // link side
    input  wire logic                 link_clk,
    input  wire logic                 link_rst_n,
    input  wire logic                 src_valid,
    input  wire wiper_pkg::cmd_word_s src_word,
    // core side
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    output logic                      dst_valid,
    output wiper_pkg::cmd_word_s      dst_word
);
    import wiper_pkg::*;

    logic      src_toggle;
    cmd_word_s src_hold;
    logic      tog_meta;
    logic      tog_sync;
    logic      tog_seen;

    // word is held until the next transaction, far longer than the crossing takes
    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            src_toggle <= 1'b0;
            src_hold   <= '0;
        end else if (src_valid) begin
            src_toggle <= ~src_toggle;
            src_hold   <= src_word;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tog_meta <= 1'b0;
            tog_sync <= 1'b0;
            tog_seen <= 1'b0;
        end else begin
            tog_meta <= src_toggle;
            tog_sync <= tog_meta;
            tog_seen <= tog_sync;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dst_valid <= 1'b0;
            dst_word  <= '0;
        end else begin
            dst_valid <= tog_sync ^ tog_seen;
            if (tog_sync ^ tog_seen) begin
                dst_word <= src_hold;
            end
        end
    end

endmodule // cmd_cross
`default_nettype wire

// ===== wiper_ctrl.sv
// two-wire slave and wiper register logic of the digital potentiometer
//
// Summary of operation
// [RULE1] wiper tap follows the volatile register, 32 taps
// [RULE2] shift in address, command, data; route data
// [RULE3] volatile write moves wiper; nonvolatile only stores
// [RULE4] nonvolatile store lasts at least 12 ms
// [RULE5] volatile lost at power-off; nonvolatile kept
// [RULE6] power-up copies nonvolatile into volatile register
// [RULE7] master starts transfers and makes the clock
// [RULE8] clock input only; data open-drain pull-down
// [RULE9] start, address, command, data, then stop
// [RULE10] falling data with clock high is start
// [RULE11] rising data with clock high is stop
// [RULE12] one bit per clock; data stable high
// [RULE13] ninth clock: device holds data low
// [RULE14] eighth address bit low writes, high no-op
// [RULE15] answer only addresses starting with 0101
// [RULE16] three-terminal: bits two,one factory; zero strapped
// [RULE17] two-terminal: three low bits all factory
// [RULE18] parts on one bus need distinct addresses
// [RULE19] wiper from data bits seven to three
// [RULE20] command codes 0x11, 0x21, 0x61, 0x51
// [RULE21] nonvolatile write keeps wiper; recall moves it
// [RULE22] recall within 20 us; factory value zero
// [RULE23] no acknowledge on wrong address or no-op
// [RULE24] apply only full acknowledged transaction ended by stop
`timescale 1ns/100ps
`default_nettype none
module wiper_ctrl #(
    parameter bit THREE_TERMINAL = 1'b1,
    parameter bit ADDR_BIT_TWO   = wiper_pkg::ADDR_BIT_TWO_DEFAULT,
    parameter bit ADDR_BIT_ONE   = wiper_pkg::ADDR_BIT_ONE_DEFAULT,
    parameter bit ADDR_BIT_ZERO  = wiper_pkg::ADDR_BIT_ZERO_DEFAULT,
    parameter int STORE_CYCLES   = wiper_pkg::STORE_CYCLES,
    parameter int RECALL_CYCLES  = wiper_pkg::RECALL_CYCLES
) (
    // core clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,
    // link clock
    input  wire logic              link_clk,
    // serial bus pins
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe_n,
    // address strap
    input  wire logic              addr_strap_in,
    // wiper and status
    output logic [wiper_pkg::TAP_BITS-1:0] wiper_tap,
    output logic                   recall_done,
    output logic                   store_busy
);
    import wiper_pkg::*;

    localparam int STORE_W  = $clog2(STORE_CYCLES + 1);
    localparam int RECALL_W = $clog2(RECALL_CYCLES + 1);

    if (STORE_CYCLES < 1 || RECALL_CYCLES < 1) begin : g_bad_timing
        $error("wiper_ctrl: timing counts must be at least one cycle");
    end

    typedef enum {
        LINK_IDLE,
        LINK_ADDR,
        LINK_CMD,
        LINK_DATA,
        LINK_HOLD,
        LINK_IGNORE
    } link_state_e;

    typedef enum {
        CORE_RECALL,
        CORE_READY,
        CORE_STORING
    } core_state_e;

    // ---------------- link clock domain ----------------

    logic        link_rst_meta;
    logic        link_rst_n;
    logic        scl_meta;
    logic        scl_sync;
    logic        scl_prev;
    logic        sda_meta;
    logic        sda_sync;
    logic        sda_prev;
    logic        strap_meta;
    logic        strap_sync;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_seen;
    logic        stop_seen;
    link_state_e link_state;
    logic [3:0]  bit_cnt;
    logic [7:0]  shift;
    logic        ack_slot;
    logic        drive_low;
    logic [7:0]  cmd_byte;
    cmd_word_s   link_word;
    logic        link_valid;
    logic [6:0]  own_addr;
    logic        addr_ok;

    // reset enters the link domain through two flops
    always_ff @(posedge link_clk) begin
        link_rst_meta <= reset_n;
        link_rst_n    <= link_rst_meta;
    end

    // pins are asynchronous to link_clk: two flops before any use
    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            scl_meta   <= 1'b1;
            scl_sync   <= 1'b1;
            scl_prev   <= 1'b1;
            sda_meta   <= 1'b1;
            sda_sync   <= 1'b1;
            sda_prev   <= 1'b1;
            strap_meta <= 1'b0;
            strap_sync <= 1'b0;
        end else begin
            scl_meta   <= scl_in;
            scl_sync   <= scl_meta;
            scl_prev   <= scl_sync;
            sda_meta   <= sda_in;
            sda_sync   <= sda_meta;
            sda_prev   <= sda_sync;
            strap_meta <= addr_strap_in;
            strap_sync <= strap_meta;
        end
    end

    assign scl_rise   = scl_sync & ~scl_prev;   // [RULE12]
    assign scl_fall   = ~scl_sync & scl_prev;
    assign start_seen = scl_sync & scl_prev & sda_prev & ~sda_sync;   // [RULE10]
    assign stop_seen  = scl_sync & scl_prev & ~sda_prev & sda_sync;   // [RULE11]

    // low address bits come from factory options; bit zero may follow the strap
    assign own_addr = {ADDR_PREFIX, ADDR_BIT_TWO, ADDR_BIT_ONE,
                       THREE_TERMINAL ? strap_sync : ADDR_BIT_ZERO};   // [RULE16] [RULE17]
    // shift holds seven address bits then the write/no-op flag
    assign addr_ok  = (shift[7:1] == own_addr) && !shift[0];   // [RULE15] [RULE14]

    // byte engine: bits sampled on scl rise, acknowledge set up on scl fall
    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            link_state <= LINK_IDLE;
            bit_cnt    <= 4'h0;
            shift      <= 8'h00;
            ack_slot   <= 1'b0;
            drive_low  <= 1'b0;
            cmd_byte   <= 8'h00;
        end else if (start_seen) begin
            // a repeated start abandons whatever was in flight
            link_state <= LINK_ADDR;
            bit_cnt    <= 4'h0;
            ack_slot   <= 1'b0;
            drive_low  <= 1'b0;
        end else if (stop_seen) begin
            link_state <= LINK_IDLE;   // [RULE11]
            bit_cnt    <= 4'h0;
            ack_slot   <= 1'b0;
            drive_low  <= 1'b0;
        end else begin
            unique case (link_state)
                LINK_IDLE, LINK_HOLD, LINK_IGNORE: begin
                    bit_cnt <= 4'h0;
                end
                LINK_ADDR, LINK_CMD, LINK_DATA: begin
                    if (scl_rise && !ack_slot && bit_cnt != BIT_COUNT_FULL) begin
                        shift   <= {shift[6:0], sda_sync};   // [RULE2]
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && ack_slot) begin
                        // ninth clock is over: release the line
                        ack_slot  <= 1'b0;
                        drive_low <= 1'b0;
                        bit_cnt   <= 4'h0;
                        if (link_state == LINK_ADDR) begin
                            link_state <= LINK_CMD;
                        end else if (link_state == LINK_CMD) begin
                            link_state <= LINK_DATA;
                        end else begin
                            link_state <= LINK_HOLD;
                        end
                    end else if (scl_fall && bit_cnt == BIT_COUNT_FULL) begin
                        if (link_state == LINK_ADDR && !addr_ok) begin
                            link_state <= LINK_IGNORE;   // [RULE23]
                        end else begin
                            ack_slot  <= 1'b1;
                            drive_low <= 1'b1;   // [RULE13]
                            if (link_state == LINK_CMD) begin
                                cmd_byte <= shift;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // a command is launched only once the data byte was acknowledged and stop seen
    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            link_valid <= 1'b0;
            link_word  <= '0;
        end else begin
            link_valid <= stop_seen && link_state == LINK_HOLD;   // [RULE24]
            if (stop_seen && link_state == LINK_HOLD) begin
                link_word.cmd  <= cmd_byte;
                link_word.data <= shift;
            end
        end
    end

    // open drain: only ever pulls low, never drives high
    assign sda_out  = 1'b0;   // [RULE8]
    assign sda_oe_n = ~drive_low;   // [RULE8]

    // ---------------- crossing ----------------

    logic      core_valid;
    cmd_word_s core_word;

    cmd_cross u_cross (
        .link_clk   (link_clk),
        .link_rst_n (link_rst_n),
        .src_valid  (link_valid),
        .src_word   (link_word),
        .clk        (clk),
        .reset_n    (reset_n),
        .dst_valid  (core_valid),
        .dst_word   (core_word)
    );

    // ---------------- core clock domain ----------------

    // the nonvolatile value is deliberately outside reset: it survives a power cycle
    logic [TAP_BITS-1:0] nv_value = NV_FACTORY_VALUE;   // [RULE5] [RULE22]
    logic [TAP_BITS-1:0] vol_value;
    logic [TAP_BITS-1:0] store_value;
    logic [TAP_BITS-1:0] rx_tap;
    core_state_e         core_state;
    logic [STORE_W-1:0]  store_cnt;
    logic [RECALL_W-1:0] recall_cnt;

    assign rx_tap = core_word.data[TAP_FIELD_LSB +: TAP_BITS];   // [RULE19]

    // sequencing of power-up recall and store
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            core_state  <= CORE_RECALL;   // [RULE6]
            recall_cnt  <= '0;
            store_cnt   <= '0;
            store_value <= '0;
        end else begin
            unique case (core_state)
                CORE_RECALL: begin
                    if (recall_cnt == RECALL_W'(RECALL_CYCLES - 1)) begin
                        core_state <= CORE_READY;   // [RULE22]
                    end else begin
                        recall_cnt <= recall_cnt + RECALL_W'(1);
                    end
                end
                CORE_READY: begin
                    if (core_valid && core_word.cmd == CMD_WRITE_NONVOLATILE) begin
                        store_value <= rx_tap;
                        store_cnt   <= '0;
                        core_state  <= CORE_STORING;
                    end else if (core_valid && core_word.cmd == CMD_STORE_TO_NONVOLATILE) begin
                        store_value <= vol_value;
                        store_cnt   <= '0;
                        core_state  <= CORE_STORING;
                    end
                end
                CORE_STORING: begin
                    // commands during the store are dropped; the master must wait
                    if (store_cnt == STORE_W'(STORE_CYCLES - 1)) begin
                        core_state <= CORE_READY;   // [RULE4]
                    end else begin
                        store_cnt <= store_cnt + STORE_W'(1);
                    end
                end
            endcase
        end
    end

    // nonvolatile value is written at the end of the store period
    always_ff @(posedge clk) begin
        if (core_state == CORE_STORING && store_cnt == STORE_W'(STORE_CYCLES - 1)) begin
            nv_value <= store_value;   // [RULE3] [RULE4]
        end
    end

    // volatile register, cleared by reset and reloaded from nonvolatile
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            vol_value <= VOL_RESET_VALUE;   // [RULE5]
        end else if (core_state == CORE_RECALL
                     && recall_cnt == RECALL_W'(RECALL_CYCLES - 1)) begin
            vol_value <= nv_value;   // [RULE6]
        end else if (core_state == CORE_READY && core_valid) begin
            if (core_word.cmd == CMD_WRITE_VOLATILE) begin
                vol_value <= rx_tap;   // [RULE3] [RULE20]
            end else if (core_word.cmd == CMD_RECALL_TO_VOLATILE) begin
                vol_value <= nv_value;   // [RULE21] [RULE20]
            end
        end
    end

    // status and tap outputs
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            recall_done <= 1'b0;
            store_busy  <= 1'b0;
        end else begin
            recall_done <= core_state != CORE_RECALL;
            store_busy  <= core_state == CORE_STORING;
        end
    end

    assign wiper_tap = vol_value;   // [RULE1]

endmodule // wiper_ctrl
`default_nettype wire

// ===== wiper_ctrl_asserts.sv
// concurrent checks on the wiper control block ports
`timescale 1ns/100ps
`default_nettype none
module wiper_ctrl_asserts #(
    parameter int STORE_CYCLES  = 50,
    parameter int RECALL_CYCLES = 10
) (
    // core and link clocks
    input wire logic                          clk,
    input wire logic                          reset_n,
    input wire logic                          link_clk,
    // serial pins
    input wire logic                          scl_in,
    input wire logic                          sda_out,
    input wire logic                          sda_oe_n,
    // status
    input wire logic [wiper_pkg::TAP_BITS-1:0] wiper_tap,
    input wire logic                          recall_done,
    input wire logic                          store_busy
);
    import wiper_pkg::*;
    logic [9:0]  rcnt;
    logic [31:0] bcnt;
    // saturating so a long run never wraps back into the window
    always_ff @(posedge clk) begin
        if (!reset_n) rcnt <= 10'h000;
        else if (rcnt != 10'h3FF) rcnt <= rcnt + 10'h001;
    end
    always_ff @(posedge clk) begin
        if (!reset_n || !store_busy) bcnt <= 32'h0;
        else bcnt <= bcnt + 32'h1;
    end
    property p_drain_only;
        @(posedge clk) disable iff (!reset_n) sda_out == 1'b0;
    endproperty
    a_drain_only: assert property (p_drain_only) else $error("data pin driven high");
    property p_reset_state;
        @(posedge clk) disable iff (!reset_n)
        $rose(reset_n) |-> wiper_tap == 5'h00 && !recall_done && !store_busy && sda_oe_n;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad state out of reset");
    property p_recall_bound;
        @(posedge clk) disable iff (!reset_n) rcnt >= RECALL_CYCLES + 4 |-> recall_done;
    endproperty
    a_recall_bound: assert property (p_recall_bound) else $error("recall too late");
    property p_store_len;
        @(posedge clk) disable iff (!reset_n) $fell(store_busy) |-> bcnt >= STORE_CYCLES - 1;
    endproperty
    a_store_len: assert property (p_store_len) else $error("store too short");
    property p_tap_hold_busy;
        @(posedge clk) disable iff (!reset_n)
        store_busy && $past(store_busy) |-> $stable(wiper_tap);
    endproperty
    a_tap_hold_busy: assert property (p_tap_hold_busy) else $error("tap moved in store");
    property p_store_after_recall;
        @(posedge clk) disable iff (!reset_n) $rose(store_busy) |-> recall_done;
    endproperty
    a_store_after_recall: assert property (p_store_after_recall) else $error("early store");
    property p_ack_edge;
        @(posedge link_clk) disable iff (!reset_n) $changed(sda_oe_n) |-> !scl_in;
    endproperty
    a_ack_edge: assert property (p_ack_edge) else $error("data moved with clock high");
    property p_ack_release;
        @(posedge link_clk) disable iff (!reset_n) $fell(sda_oe_n) |-> ##[1:40] sda_oe_n;
    endproperty
    a_ack_release: assert property (p_ack_release) else $error("ack held too long");
    c_ack: cover property (@(posedge link_clk) disable iff (!reset_n) $fell(sda_oe_n));
    c_store: cover property (@(posedge clk) disable iff (!reset_n) $fell(store_busy));
    c_recall: cover property (@(posedge clk) disable iff (!reset_n) $rose(recall_done));
endmodule // wiper_ctrl_asserts
`default_nettype wire

// ===== i2c_master_model.sv
// two-wire bus master model that drives the serial clock and data
`timescale 1ns/100ps
`default_nettype none
module i2c_master_model #(
    parameter int Q = 3
) (
    // timing base
    input wire logic  clk,
    // bus
    output var logic  scl,
    output var logic  sda_drv,
    input wire logic  sda_in
);
    // both lines idle high; clock stands still between frames
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic qwait;
        repeat (Q) @(posedge clk);
    endtask
    // master alone begins a frame and makes every clock pulse
    task automatic bus_start;
        sda_drv <= 1'b1;
        scl <= 1'b1;
        qwait();
        sda_drv <= 1'b0;
        qwait();
        scl <= 1'b0;
        qwait();
    endtask
    // data set while clock low, held across the high phase
    task automatic send_bit(input logic b, output logic seen);
        sda_drv <= b;
        qwait();
        scl <= 1'b1;
        qwait();
        seen = sda_in;
        qwait();
        scl <= 1'b0;
        qwait();
    endtask
    // eight bits msb first, then a released ninth bit for the ack
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic seen;
        for (int i = 7; i >= 0; i--) send_bit(b[i], seen);
        send_bit(1'b1, seen);
        ack = !seen;
    endtask
    task automatic bus_stop;
        sda_drv <= 1'b0;
        qwait();
        scl <= 1'b1;
        qwait();
        sda_drv <= 1'b1;
        qwait();
    endtask
endmodule // i2c_master_model
`default_nettype wire

// ===== tb_wiper_ctrl.sv
// self-checking bench for the wiper control block
`timescale 1ns/100ps
`default_nettype none
module tb_wiper_ctrl;
    import wiper_pkg::*;
    localparam int ST = 50;
    logic       clk = 1'b0;
    logic       link_clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       strap = 1'b0;
    logic       scl;
    logic       sda_drv;
    logic       sda_out;
    logic       sda_oe_n;
    logic [4:0] wiper_tap;
    logic       recall_done;
    logic       store_busy;
    wire        sda = sda_drv & (sda_oe_n | sda_out);
    int         n_mismatch = 0;
    int         n_tests = 0;
    initial forever #25 clk = ~clk;
    // odd offset keeps the link clock out of phase with the core clock
    initial begin
        #7;
        forever #15 link_clk = ~link_clk;
    end
    wiper_ctrl #(.STORE_CYCLES(ST), .RECALL_CYCLES(10)) wiper_ctrl_i (
        .clk(clk), .reset_n(reset_n), .link_clk(link_clk), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .addr_strap_in(strap), .wiper_tap(wiper_tap),
        .recall_done(recall_done), .store_busy(store_busy));
    i2c_master_model i2c_master_model_i (
        .clk(clk), .scl(scl), .sda_drv(sda_drv), .sda_in(sda));
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_tap(input logic [4:0] exp);
        n_tests++;
        if (wiper_tap !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, wiper_tap, exp);
        end
    endtask
    task automatic give_up;
        n_mismatch++;
        print_verdict();
    endtask
    task automatic xfer(input logic [6:0] a, input logic nop, input logic [7:0] cmd,
                        input logic [7:0] data, input int nb, input logic exp_ack);
        logic ack;
        i2c_master_model_i.bus_start();
        i2c_master_model_i.send_byte({a, nop}, ack);
        check_bit(ack, exp_ack);
        if (nb > 0) i2c_master_model_i.send_byte(cmd, ack);
        if (nb > 0) check_bit(ack, exp_ack);
        if (nb > 1) i2c_master_model_i.send_byte(data, ack);
        if (nb > 1) check_bit(ack, exp_ack);
        i2c_master_model_i.bus_stop();
        repeat (16) @(posedge clk);
    endtask
    task automatic wait_recall;
        int n;
        n = 0;
        while (recall_done !== 1'b1) begin
            @(posedge clk);
            n++;
            if (n > 100) give_up();
        end
    endtask
    // busy already ran for up to the 16 settle cycles of the transfer
    task automatic wait_store;
        int n;
        n = 0;
        while (store_busy === 1'b1) begin
            @(posedge clk);
            n++;
            if (n > 500) give_up();
        end
        check_bit(n >= ST - 16, 1'b1);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        wait_recall();
        check_tap(5'h00);
        xfer(7'h28, 1'b0, 8'h11, 8'hAF, 2, 1'b1);
        check_tap(5'h15);
        xfer(7'h28, 1'b0, 8'h11, 8'hFF, 2, 1'b1);
        check_tap(5'h1F);
        xfer(7'h28, 1'b1, 8'h11, 8'h00, 2, 1'b0);
        xfer(7'h38, 1'b0, 8'h11, 8'h00, 2, 1'b0);
        xfer(7'h29, 1'b0, 8'h11, 8'h00, 2, 1'b0);
        check_tap(5'h1F);
        @(posedge clk);
        strap <= 1'b1;
        repeat (8) @(posedge clk);
        xfer(7'h29, 1'b0, 8'h11, 8'h40, 2, 1'b1);
        check_tap(5'h08);
        strap <= 1'b0;
        repeat (8) @(posedge clk);
        xfer(7'h28, 1'b0, 8'h11, 8'h00, 1, 1'b1);
        check_tap(5'h08);
        xfer(7'h28, 1'b0, 8'h21, 8'h90, 2, 1'b1);
        check_tap(5'h08);
        check_bit(store_busy, 1'b1);
        wait_store();
        xfer(7'h28, 1'b0, 8'h61, 8'h00, 2, 1'b1);
        check_tap(5'h12);
        xfer(7'h28, 1'b0, 8'h11, 8'h18, 2, 1'b1);
        xfer(7'h28, 1'b0, 8'h51, 8'h00, 2, 1'b1);
        wait_store();
        xfer(7'h28, 1'b0, 8'h11, 8'h00, 2, 1'b1);
        check_tap(5'h00);
        reset_n <= 1'b0;
        repeat (6) @(posedge clk);
        check_tap(5'h00);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        wait_recall();
        check_tap(5'h03);
        print_verdict();
    end
endmodule // tb_wiper_ctrl
bind wiper_ctrl wiper_ctrl_asserts #(.STORE_CYCLES(STORE_CYCLES), .RECALL_CYCLES(RECALL_CYCLES))
    chk_i (.clk(clk), .reset_n(reset_n), .link_clk(link_clk), .scl_in(scl_in),
           .sda_out(sda_out), .sda_oe_n(sda_oe_n), .wiper_tap(wiper_tap),
           .recall_done(recall_done), .store_busy(store_busy));
`default_nettype wire
